// ===== perc_pkg.sv
`default_nettype none
package perc_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_STRIDE   = 8'h10;
  localparam logic [7:0] OFS_RATE_EN   = 8'h00;
  localparam logic [7:0] OFS_CAPT_ATTR = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h40;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h44;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h48;

  // ---------------------------------------------------------------
  // Error bit positions, shared by detect events and enable bits
  // ---------------------------------------------------------------
  localparam int unsigned BIT_VENDOR       = 31;
  localparam int unsigned BIT_SYMBOL_CRC   = 22;
  localparam int unsigned BIT_ACK_BAD_ID   = 21;
  localparam int unsigned BIT_NOT_ACCEPTED = 20;
  localparam int unsigned BIT_PKT_ORDER    = 19;
  localparam int unsigned BIT_PKT_CRC      = 18;
  localparam int unsigned BIT_OVERSIZE     = 17;
  localparam int unsigned BIT_STRAY_RESP   = 5;
  localparam int unsigned BIT_PROTOCOL     = 4;
  localparam int unsigned BIT_DELINEATION  = 2;
  localparam int unsigned BIT_UNREQ_ACK    = 1;
  localparam int unsigned BIT_LINK_TIMEOUT = 0;

  // Writable enable bits; everything else reads zero
  localparam logic [31:0] RATE_EN_MASK  = 32'h807e0037;
  localparam logic [31:0] RATE_EN_RESET = 32'h00000000;
  // Detect bits whose event comes with capturable content
  localparam logic [31:0] CAPT_OK_MASK  = 32'h805e0012;
  // Largest permitted packet, bytes (reported by the receiver)
  localparam int unsigned MAX_PKT_BYTES = 276;

  // ---------------------------------------------------------------
  // Capture attribute fields
  // ---------------------------------------------------------------
  localparam int unsigned ATTR_KIND_LSB   = 30;
  localparam int unsigned ATTR_TYPE_LSB   = 24;
  localparam int unsigned ATTR_DETAIL_LSB = 4;
  localparam int unsigned ATTR_VALID_BIT  = 0;
  localparam logic [1:0]  KIND_PACKET     = 2'h0;
  localparam logic [1:0]  KIND_SYMBOL     = 2'h1;
  localparam logic [1:0]  KIND_VENDOR     = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] err_evt;        // One-cycle pulses, detect bit layout
    logic [1:0]  item_kind;      // Kind of item that raised the error
    logic [19:0] vendor_detail;  // Extra detail stored with a capture
  } perc_evt_t;

  typedef struct packed {
    logic [1:0]  captured_item_kind;
    logic [4:0]  error_code;
    logic [19:0] vendor_capture_detail;
    logic        capture_valid_flag;
  } perc_capt_t;

endpackage
`default_nettype wire

// ===== perc_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Each of the four ports has its own enable and capture attribute register.
// - Enable bit 31 lets vendor-specific errors advance the port error rate.
// - Enable bit 22 lets control symbols with bad check value count.
// - Enable bit 21 lets acknowledge symbols with unexpected ackID count.
// - Enable bit 20 lets packet-not-accepted symbols count.
// - Enable bit 19 lets out-of-sequence packet ackIDs count.
// - Enable bit 18 lets packets with bad CRC count.
// - Enable bit 17 lets packets over 276 bytes count.
// - Enable bit 5 lets link-responses with non-outstanding ackID count.
// - Enable bit 4 lets protocol errors count.
// - Enable bit 2 lets delineation errors count.
// - Enable bit 1 lets unsolicited acknowledge symbols count.
// - Enable bit 0 lets link time-outs count.
// - Enable bits read-write, reset zero; reserved bits read zero.
// - Item kind codes: 00 packet, 01 control symbol, 10 vendor content.
// - Captured-error field holds encoded position of the detect bit.
// - Hardware sets valid on capture; writing 0 clears it and unlocks.
module perc_regs
  import perc_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Error events from the port logic
  input  wire perc_evt_t         port_evt   [PORTS],
  // Error-rate counter advance, one pulse per counted event
  output logic [PORTS-1:0]       rate_count_pulse,
  // Error detect flag pulses, enable-independent
  output logic [PORTS-1:0]       err_flag_pulse,
  // Interrupt
  output logic                   irq
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------

  // Gate detect events by their enable bits, one bit per error type
  function automatic logic [31:0] gate_events(input logic [31:0] evt,
                                              input logic [31:0] en);
    logic [31:0] g;
    g = 32'h00000000;
    g[BIT_VENDOR]       = evt[BIT_VENDOR]       & en[BIT_VENDOR];
    g[BIT_SYMBOL_CRC]   = evt[BIT_SYMBOL_CRC]   & en[BIT_SYMBOL_CRC];
    g[BIT_ACK_BAD_ID]   = evt[BIT_ACK_BAD_ID]   & en[BIT_ACK_BAD_ID];
    g[BIT_NOT_ACCEPTED] = evt[BIT_NOT_ACCEPTED] & en[BIT_NOT_ACCEPTED];
    g[BIT_PKT_ORDER]    = evt[BIT_PKT_ORDER]    & en[BIT_PKT_ORDER];
    g[BIT_PKT_CRC]      = evt[BIT_PKT_CRC]      & en[BIT_PKT_CRC];
    g[BIT_OVERSIZE]     = evt[BIT_OVERSIZE]     & en[BIT_OVERSIZE];
    g[BIT_STRAY_RESP]   = evt[BIT_STRAY_RESP]   & en[BIT_STRAY_RESP];
    g[BIT_PROTOCOL]     = evt[BIT_PROTOCOL]     & en[BIT_PROTOCOL];
    g[BIT_DELINEATION]  = evt[BIT_DELINEATION]  & en[BIT_DELINEATION];
    g[BIT_UNREQ_ACK]    = evt[BIT_UNREQ_ACK]    & en[BIT_UNREQ_ACK];
    g[BIT_LINK_TIMEOUT] = evt[BIT_LINK_TIMEOUT] & en[BIT_LINK_TIMEOUT];
    return g;
  endfunction

  // Position of the highest capturable detect bit, as a 5-bit code
  function automatic logic [4:0] encode_error(input logic [31:0] evt);
    logic [4:0] code;
    code = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (evt[i]) begin
        code = 5'(i);
      end
    end
    return code;
  endfunction

  // Address decode: port index and register within the port window
  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs,
                                    output int unsigned      p);
    logic hit;
    hit = 1'b0;
    p   = 0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (i < PORTS && a == ADDR_W'(i * PORT_STRIDE + ofs)) begin
        hit = 1'b1;
        p   = i;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] pack_attr(input perc_capt_t c);
    logic [31:0] v;
    v = 32'h00000000;
    v[ATTR_KIND_LSB +: 2]    = c.captured_item_kind;
    v[ATTR_TYPE_LSB +: 5]    = c.error_code;
    v[ATTR_DETAIL_LSB +: 20] = c.vendor_capture_detail;
    v[ATTR_VALID_BIT]        = c.capture_valid_flag;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0]       rate_en_q   [PORTS];
  logic [31:0]       rate_en_d   [PORTS];
  perc_capt_t        capt_q      [PORTS];
  perc_capt_t        capt_d      [PORTS];
  logic [PORTS-1:0]  irq_stat_q;
  logic [PORTS-1:0]  irq_stat_d;
  logic [PORTS-1:0]  irq_en_q;
  logic [PORTS-1:0]  irq_en_d;
  logic [PORTS-1:0]  rate_pulse_q;
  logic [PORTS-1:0]  rate_pulse_d;
  logic [PORTS-1:0]  flag_pulse_q;
  logic [PORTS-1:0]  flag_pulse_d;

  logic              aw_full_q,  aw_full_d;
  logic [ADDR_W-1:0] aw_addr_q,  aw_addr_d;
  logic              w_full_q,   w_full_d;
  logic [31:0]       w_data_q,   w_data_d;
  logic [3:0]        w_strb_q,   w_strb_d;
  logic              bvalid_q,   bvalid_d;
  logic [1:0]        bresp_q,    bresp_d;
  logic              rvalid_q,   rvalid_d;
  logic [31:0]       rdata_q,    rdata_d;
  logic [1:0]        rresp_q,    rresp_d;

  logic              do_write;
  logic [31:0]       wr_mask;

  // ---------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------
  // Address and data are latched separately so either may arrive first
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;
  assign wr_mask       = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                          {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Protection bits carry no meaning here; access is not restricted
  always_comb begin
    int unsigned p;
    logic        hit;
    logic [31:0] ok_evt;
    logic [31:0] gated;
    p            = 0;
    hit          = 1'b0;
    ok_evt       = 32'h00000000;
    gated        = 32'h00000000;
    aw_full_d    = aw_full_q;
    aw_addr_d    = aw_addr_q;
    w_full_d     = w_full_q;
    w_data_d     = w_data_q;
    w_strb_d     = w_strb_q;
    bvalid_d     = bvalid_q;
    bresp_d      = bresp_q;
    rvalid_d     = rvalid_q;
    rdata_d      = rdata_q;
    rresp_d      = rresp_q;
    irq_en_d     = irq_en_q;
    irq_stat_d   = irq_stat_q;
    rate_pulse_d = '0;
    flag_pulse_d = '0;
    for (int i = 0; i < PORTS; i++) begin
      rate_en_d[i] = rate_en_q[i];
      capt_d[i]    = capt_q[i];
    end

    // Channel capture
    if (s_axi_awvalid && !aw_full_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end

    // Register writes; clears come first so a same-cycle event wins
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      if (port_hit(aw_addr_q, OFS_RATE_EN, p)) begin
        rate_en_d[p] = ((rate_en_q[p] & ~wr_mask) | (w_data_q & wr_mask))
                       & RATE_EN_MASK;
      end else if (port_hit(aw_addr_q, OFS_CAPT_ATTR, p)) begin
        if (w_strb_q[0] && !w_data_q[ATTR_VALID_BIT]) begin
          capt_d[p].capture_valid_flag = 1'b0;
        end
      end else if (aw_addr_q == OFS_IRQ_EN) begin
        if (w_strb_q[0]) begin
          irq_en_d = w_data_q[PORTS-1:0];
        end
      end else if (aw_addr_q == OFS_IRQ_CLR) begin
        if (w_strb_q[0]) begin
          irq_stat_d = irq_stat_q & ~w_data_q[PORTS-1:0];
        end
      end else if (aw_addr_q != OFS_IRQ_STAT) begin
        bresp_d = RESP_SLVERR;
      end
    end

    // Per-port event handling, independent copies
    for (int i = 0; i < PORTS; i++) begin
      gated           = gate_events(port_evt[i].err_evt, rate_en_q[i]);
      rate_pulse_d[i] = |gated;
      flag_pulse_d[i] = |port_evt[i].err_evt;
      ok_evt          = port_evt[i].err_evt & CAPT_OK_MASK;
      // Capture only while unlocked; a clear in this cycle unlocks at once,
      // so an event arriving with the clear is kept rather than lost
      if (|ok_evt && !capt_d[i].capture_valid_flag) begin
        capt_d[i].captured_item_kind    = port_evt[i].item_kind;
        capt_d[i].error_code            = encode_error(ok_evt);
        capt_d[i].vendor_capture_detail = port_evt[i].vendor_detail;
        capt_d[i].capture_valid_flag    = 1'b1;
        irq_stat_d[i]                   = 1'b1;
      end
    end

    // Reads
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h00000000;
      if (port_hit(s_axi_araddr, OFS_RATE_EN, p)) begin
        rdata_d = rate_en_q[p] & RATE_EN_MASK;
      end else if (port_hit(s_axi_araddr, OFS_CAPT_ATTR, p)) begin
        rdata_d = pack_attr(capt_q[p]);
      end else if (s_axi_araddr == OFS_IRQ_STAT) begin
        rdata_d[PORTS-1:0] = irq_stat_q;
      end else if (s_axi_araddr == OFS_IRQ_EN) begin
        rdata_d[PORTS-1:0] = irq_en_q;
      end else if (s_axi_araddr == OFS_IRQ_CLR) begin
        rdata_d = 32'h00000000;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
    hit = 1'b0;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < PORTS; i++) begin
        rate_en_q[i] <= RATE_EN_RESET;
        capt_q[i]    <= '0;
      end
      irq_stat_q   <= '0;
      irq_en_q     <= '0;
      rate_pulse_q <= '0;
      flag_pulse_q <= '0;
      aw_full_q    <= 1'b0;
      aw_addr_q    <= '0;
      w_full_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h00000000;
      rresp_q      <= RESP_OKAY;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        rate_en_q[i] <= rate_en_d[i];
        capt_q[i]    <= capt_d[i];
      end
      irq_stat_q   <= irq_stat_d;
      irq_en_q     <= irq_en_d;
      rate_pulse_q <= rate_pulse_d;
      flag_pulse_q <= flag_pulse_d;
      aw_full_q    <= aw_full_d;
      aw_addr_q    <= aw_addr_d;
      w_full_q     <= w_full_d;
      w_data_q     <= w_data_d;
      w_strb_q     <= w_strb_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Pulses are registered, so they trail the event by one cycle
  assign rate_count_pulse = rate_pulse_q;
  assign err_flag_pulse   = flag_pulse_q;
  assign irq              = |(irq_stat_q & irq_en_q);

endmodule
`default_nettype wire

// ===== perc_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module perc_regs_properties
  import perc_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Event side
  input wire perc_evt_t         port_evt [PORTS],
  input wire logic [PORTS-1:0]  rate_count_pulse,
  input wire logic [PORTS-1:0]  err_flag_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Both halves of a write taken on one edge
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  write_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  slot_held_a: assert property (aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write slot accepted a second request");
  bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  // Per port: flags follow every event, rate pulses only kinds that have an enable bit
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    flag_follows_a: assert property (|port_evt[g].err_evt |=> err_flag_pulse[g])
      else $error("error flag pulse missing");
    flag_cause_a: assert property (err_flag_pulse[g] |-> $past(|port_evt[g].err_evt))
      else $error("error flag without event");
    rate_cause_a: assert property (rate_count_pulse[g] |->
      $past(|(port_evt[g].err_evt & RATE_EN_MASK)))
      else $error("rate pulse without countable event");
  end
endmodule

bind perc_regs perc_regs_properties #(.PORTS(PORTS)) u_perc_regs_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_evt(port_evt),
  .rate_count_pulse(rate_count_pulse), .err_flag_pulse(err_flag_pulse));
`default_nettype wire

// ===== perc_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module perc_link_partner
  import perc_pkg::*;
#(
  parameter int unsigned PORTS = NUM_PORTS
) (
  // Clock
  input wire logic       aclk,
  // Request from the bench
  input wire logic       fire,
  input wire logic [1:0] psel,
  input wire perc_evt_t  evt_in,
  // Events toward the block
  output var perc_evt_t  port_evt [PORTS]
);
  perc_evt_t evt_d [PORTS];
  perc_evt_t evt_q [PORTS];

  // Idle ports carry nothing, so a stale event would show as a stray pulse
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      evt_d[p] = '0;
      if (fire && psel == 2'(p)) evt_d[p] = evt_in;
    end
  end

  // Registered so each event lasts exactly one cycle
  always_ff @(posedge aclk) begin
    evt_q <= evt_d;
  end
  assign port_evt = evt_q;
endmodule
`default_nettype wire

// ===== perc_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); \
  end \
end
module perc_regs_bench;
  import perc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, en_mask;
  logic [3:0]  rate_p, flag_p;
  logic [1:0]  bresp, rresp, psel;
  perc_evt_t   evt_in;
  perc_evt_t   port_evt [NUM_PORTS];
  int          failures, cmp_count, rc[4], fc[4];
  localparam int EB[12] = '{31, 22, 21, 20, 19, 18, 17, 5, 4, 2, 1, 0};
  localparam logic [19:0] DET = 20'h3c5a1;

  perc_regs u_perc_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_evt(port_evt),
    .rate_count_pulse(rate_p), .err_flag_pulse(flag_p), .irq(irq));
  perc_link_partner u_perc_link_partner (.aclk(aclk), .fire(fire), .psel(psel),
    .evt_in(evt_in), .port_evt(port_evt));

  // Clock, and pulse counters read at the falling edge to stay clear of updates
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    for (int p = 0; p < 4; p++) if (aresetn) rc[p] += int'(rate_p[p]);
    for (int p = 0; p < 4; p++) if (aresetn) fc[p] += int'(flag_p[p]);
  end

  // ------------------------------------------------------------------
  // Bus tasks: ready is judged before the edge, released just after it
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    `CHK("write response", er, r)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, dh;
    araddr  <= a;
    arvalid <= 1'b1;
    dh = 1'b0;
    while (!dh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      dh = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK($sformatf("register %h", a), e, d)
  endtask

  task automatic irq_is(input logic e);
    @(negedge aclk);
    `CHK("irq", e, irq)
    @(posedge aclk);
  endtask

  // One event on one port, then time for the pulses to land
  task automatic ev(input int p, input logic [31:0] b, input logic [1:0] k);
    fire   <= 1'b1;
    psel   <= 2'(p);
    evt_in <= '{err_evt: b, item_kind: k, vendor_detail: DET};
    @(posedge aclk);
    fire <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    for (int p = 0; p < 4; p++) rchk(8'(16 * p), 32'h0);
    for (int p = 0; p < 4; p++) rchk(8'(16 * p + 4), 32'h0);
    irq_is(1'b0);
    for (int p = 0; p < 4; p++) wr(8'(16 * p), 32'hffffffff >> p, RESP_OKAY);
    for (int p = 0; p < 4; p++) rchk(8'(16 * p), (32'hffffffff >> p) & en_mask);
    wr(8'h04, 32'hffffffff, RESP_OKAY);
    rchk(8'h04, 32'h0);
  endtask

  // Each enable alone counts its kind; cleared, the kind is only flagged
  task automatic t_count;
    int p, r0, f0;
    logic [31:0] b;
    for (int i = 0; i < 12; i++) begin
      p = i % 4;
      b = 32'h1 << EB[i];
      wr(8'(16 * p), b, RESP_OKAY);
      r0 = rc[p];
      f0 = fc[p];
      ev(p, b, 2'b00);
      `CHK("counted", 1, rc[p] - r0)
      wr(8'(16 * p), en_mask & ~b, RESP_OKAY);
      ev(p, b, 2'b00);
      `CHK("not counted", 1, rc[p] - r0)
      `CHK("flagged", 2, fc[p] - f0)
    end
    r0 = rc[0];
    ev(0, ~en_mask, 2'b00);
    `CHK("reserved counted", 0, rc[0] - r0)
  endtask

  // Capture, lock, clear and all three item kinds on port 1
  task automatic t_capture;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h14, 32'h0, RESP_OKAY);
    wr(8'h48, 32'hf, RESP_OKAY);
    wr(8'h44, 32'hf, RESP_OKAY);
    irq_is(1'b0);
    ev(1, 32'h1 << 18, 2'b00);
    rchk(8'h14, {2'b00, 1'b0, 5'd18, DET, 3'b0, 1'b1});
    rchk(8'h40, 32'h2);
    irq_is(1'b1);
    ev(1, 32'h1 << 22, 2'b01);
    rchk(8'h14, {2'b00, 1'b0, 5'd18, DET, 3'b0, 1'b1});
    wr(8'h14, 32'h0, RESP_OKAY);
    ev(1, 32'h1 << 21, 2'b01);
    rd(8'h14, d, r);
    `CHK("capture valid", 1'b0, d[0])
    ev(1, 32'h1 << 22, 2'b01);
    rchk(8'h14, {2'b01, 1'b0, 5'd22, DET, 3'b0, 1'b1});
    wr(8'h14, 32'h0, RESP_OKAY);
    ev(1, 32'h80400000, 2'b10);
    rchk(8'h14, {2'b10, 1'b0, 5'd31, DET, 3'b0, 1'b1});
    wr(8'h44, 32'h0, RESP_OKAY);
    irq_is(1'b0);
    wr(8'h44, 32'hf, RESP_OKAY);
    irq_is(1'b1);
    wr(8'h48, 32'h2, RESP_OKAY);
    irq_is(1'b0);
    wr(8'h80, 32'hffffffff, RESP_SLVERR);
    rd(8'h80, d, r);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run is about 300 cycles; the limit leaves ample margin
  initial begin
    repeat (50000) @(posedge aclk);
    failures++;
    summarize();
  end

  initial begin
    // Response readies stay high, so back-to-back calls never toggle them twice
    {aresetn, awvalid, wvalid, arvalid, fire} = '0;
    bready = 1'b1;
    rready = 1'b1;
    {awaddr, araddr, wdata, psel} = '0;
    evt_in = '0;
    en_mask = '0;
    for (int i = 0; i < 12; i++) en_mask[EB[i]] = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_count();
    t_capture();
    summarize();
  end
endmodule
`default_nettype wire
